// ### design/aas_defines.vh
// register map, field positions, reset values and timing for the sequencer
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH

// register indices; byte address is four times the index
`define AAS_IDX_RESULT      16'h402D
`define AAS_IDX_CONTROL     16'h402E
`define AAS_IDX_SOURCE      16'h402F
`define AAS_ADDR_W          18

// result register fields
`define AAS_RES_TAG_HI      15
`define AAS_RES_TAG_LO      12
`define AAS_RES_DATA_HI     11
`define AAS_RES_DATA_LO     0
`define AAS_RES_RESET       16'h0000

// control register fields
`define AAS_CTL_ON          15
`define AAS_CTL_GO          14
`define AAS_CTL_SLEEP       12
`define AAS_CTL_RATE_HI     5
`define AAS_CTL_RATE_LO     0
`define AAS_CTL_RESET       16'h0000

// source register fields
`define AAS_SRC_SUPPLY      6
`define AAS_SRC_TEMP        4
`define AAS_SRC_PIN12       2
`define AAS_SRC_PIN11       1
`define AAS_SRC_PIN10       0
`define AAS_SRC_RESET       16'h0000

// source tags reported beside each result
`define AAS_TAG_PIN10       4'h1
`define AAS_TAG_PIN11       4'h2
`define AAS_TAG_PIN12       4'h3
`define AAS_TAG_TEMP        4'h5
`define AAS_TAG_SUPPLY      4'h7

// rate decode: low codes step by 2 sps, high codes by 16 sps
`define AAS_RATE_LO_STEP    9'h002
`define AAS_RATE_HI_STEP    9'h010

// clock: 40 MHz, period 25 ns
`define AAS_CLK_PERIOD_NS   25
`define AAS_CLK_HZ          40000000

`endif

// ### design/aas_rate_div.v
// periodic conversion tick generator driven by the rate code
`timescale 1ns/1ps
`include "aas_defines.vh"

module aas_rate_div #(
	parameter CLK_HZ = `AAS_CLK_HZ
) (
	input  wire       clk_in,
	input  wire       rst_b_in,
	input  wire       run_in,
	input  wire [5:0] rate_in,
	output reg        tick_out
);

	localparam [26:0] HZ = CLK_HZ;

	reg  [26:0] acc_r;
	reg  [26:0] acc_nxt;
	reg  [8:0]  sps;
	wire [26:0] sum;

	// code 32 yields zero samples per second, so it never ticks
	always @* begin
		if (rate_in[5]) begin
			sps = {4'h0, rate_in[4:0]} * `AAS_RATE_HI_STEP;
		end else begin
			sps = {4'h0, rate_in[4:0]} * `AAS_RATE_LO_STEP;
		end
	end

	// fractional accumulator keeps the mean rate exact for every code
	assign sum = acc_r + {18'h00000, sps};

	always @* begin
		acc_nxt = sum;
		if (!run_in) begin
			acc_nxt = 27'h0000000;
		end else if (sum >= HZ) begin
			acc_nxt = sum - HZ;
		end
	end

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc_r    <= 27'h0000000;
			tick_out <= 1'b0;
		end else begin
			acc_r    <= acc_nxt;
			tick_out <= run_in && (sum >= HZ);
		end
	end

endmodule // aas_rate_div

// ### design/aas_sequencer.v
// auxiliary converter sequencer: APB registers, scheduling, result capture
// Function
// - each result carries a 4-bit source tag: 1/2/3 pins 10-12, 5 temp, 7 supply.
// - the latest 12-bit unsigned result sits in bits 11:0, zero after reset.
// - voltage results are passed unchanged from the core at 1.465 mV per step.
// - temperature results are passed unchanged so that C = (498 - code) / 1.09.
// - the master enable is bit 15, zero at reset, cleared on entering OFF.
// - with a nonzero rate, periodic conversions run only while go (bit 14) is 1.
// - with rate 0, writing go starts one conversion and go clears when it ends.
// - sleep-follow (bit 12) 0 stops the converter in sleep, 1 obeys the enable.
// - supply, temp and pins 12/11/10 are picked by bits 6, 4, 2, 1 and 0.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "aas_defines.vh"

module aas_sequencer #(
	parameter CLK_HZ = `AAS_CLK_HZ
) (
	input  wire        clk_in,
	input  wire        rst_b_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [17:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	input  wire        off_state_in,
	input  wire        sleep_state_in,
	output reg         conv_power_out,
	output reg         conv_start_out,
	output reg  [3:0]  conv_tag_out,
	input  wire        conv_done_in,
	input  wire [11:0] conv_data_in
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;

	localparam [17:0] A_RESULT  = {`AAS_IDX_RESULT, 2'b00};
	localparam [17:0] A_CONTROL = {`AAS_IDX_CONTROL, 2'b00};
	localparam [17:0] A_SOURCE  = {`AAS_IDX_SOURCE, 2'b00};

	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg         on_r;
	reg         go_r;
	reg         go_nxt;
	reg         slp_r;
	reg  [5:0]  rate_r;
	reg  [4:0]  pick_r;
	reg  [11:0] data_r;
	reg  [3:0]  tag_r;
	reg  [2:0]  last_r;
	reg  [2:0]  cur_r;
	reg         pend_r;
	reg         done_s1_r;
	reg         done_s2_r;
	reg         done_s3_r;
	reg  [11:0] data_s1_r;
	reg  [11:0] data_s2_r;
	wire        active;
	wire        manual;
	wire        tick;
	wire        done_rise;
	wire        access;
	wire        wr_take;
	wire [2:0]  next_idx;
	wire        any_pick;
	wire        trigger;
	wire        finish;
	wire        wr_ctl;
	wire        wr_src;
	wire        run_rate;

	// round-robin search: first picked input after the last one converted
	function [2:0] aas_next;
		input [4:0] picks;
		input [2:0] last;
		integer     k;
		reg   [3:0] pos;
		reg   [2:0] idx;
		reg         hit;
		begin
			aas_next = last;
			hit = 1'b0;
			for (k = 1; k <= 5; k = k + 1) begin
				// 4 bits wide so the wrap past 7 cannot skip a channel
				pos = {1'b0, last} + k[3:0];
				if (pos >= 4'd5) begin
					pos = pos - 4'd5;
				end
				idx = pos[2:0];
				if (!hit && picks[idx]) begin
					aas_next = idx;
					hit = 1'b1;
				end
			end
		end
	endfunction

	// channel index to reported source tag
	function [3:0] aas_tag;
		input [2:0] idx;
		begin
			case (idx)
				3'd0:    aas_tag = `AAS_TAG_PIN10;
				3'd1:    aas_tag = `AAS_TAG_PIN11;
				3'd2:    aas_tag = `AAS_TAG_PIN12;
				3'd3:    aas_tag = `AAS_TAG_TEMP;
				default: aas_tag = `AAS_TAG_SUPPLY;
			endcase
		end
	endfunction

	function aas_mapped;
		input [17:0] a;
		begin
			aas_mapped = (a == A_RESULT) || (a == A_CONTROL) ||
				(a == A_SOURCE);
		end
	endfunction

	// APB: one wait cycle, pready from a flop; write lands on the ready edge
	assign access  = psel_in && penable_in;
	assign wr_take = access && pready_out && pwrite_in &&
		aas_mapped(paddr_in);
	// one strobe per writable register
	assign wr_ctl  = wr_take && (paddr_in == A_CONTROL);
	assign wr_src  = wr_take && (paddr_in == A_SOURCE);

	assign active   = on_r && (!sleep_state_in || slp_r);
	assign manual   = (rate_r == 6'h00);
	assign any_pick = |pick_r;
	assign next_idx = aas_next(pick_r, last_r);
	assign done_rise = done_s2_r && !done_s3_r;
	assign finish    = (state_r == ST_WAIT) && done_rise;

	// manual starts on go; periodic waits for a pending tick while go holds
	assign trigger = active && any_pick && go_r &&
		(manual || pend_r);

	// divider only runs in automatic mode while powered and go is set
	assign run_rate = active && go_r && !manual;

	aas_rate_div #(
		.CLK_HZ (CLK_HZ)
	) u_rate (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.run_in   (run_rate),
		.rate_in  (rate_r),
		.tick_out (tick)
	);

	// done and data come from the analogue core: two sync flops each, plus a third on done for the edge;
	// data holds while done is high, so both stages agree at finish
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
			data_s1_r <= 12'h000;
			data_s2_r <= 12'h000;
		end else begin
			done_s1_r <= conv_done_in;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
			data_s1_r <= conv_data_in;
			data_s2_r <= data_s1_r;
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (trigger) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!active || done_rise) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// a software write in the finishing cycle wins over the self-clear
	always @* begin
		go_nxt = go_r;
		if (manual && finish) begin
			go_nxt = 1'b0;
		end
		if (manual && go_r && active && !any_pick) begin
			go_nxt = 1'b0;
		end
		if (wr_ctl) begin
			go_nxt = pwdata_in[`AAS_CTL_GO];
		end
	end

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			on_r   <= 1'b0;
			go_r   <= 1'b0;
			slp_r  <= 1'b0;
			rate_r <= 6'h00;
			pick_r <= 5'h00;
		end else begin
			go_r <= go_nxt;
			if (wr_ctl) begin
				on_r   <= pwdata_in[`AAS_CTL_ON];
				slp_r  <= pwdata_in[`AAS_CTL_SLEEP];
				rate_r <= pwdata_in[`AAS_CTL_RATE_HI:`AAS_CTL_RATE_LO];
			end
			// off wins over a same-cycle write; go is left as it is
			if (off_state_in) begin
				on_r <= 1'b0;
			end
			if (wr_src) begin
				pick_r <= {pwdata_in[`AAS_SRC_SUPPLY],
					pwdata_in[`AAS_SRC_TEMP],
					pwdata_in[`AAS_SRC_PIN12],
					pwdata_in[`AAS_SRC_PIN11],
					pwdata_in[`AAS_SRC_PIN10]};
			end
		end
	end

	// sequencing and start pulses
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r        <= ST_IDLE;
			last_r         <= 3'd4;
			cur_r          <= 3'd0;
			conv_start_out <= 1'b0;
			conv_tag_out   <= 4'h0;
			conv_power_out <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			// losing power mid-conversion abandons it, no result kept
			conv_power_out <= active;
			conv_start_out <= 1'b0;
			if (state_r == ST_IDLE && trigger) begin
				conv_start_out <= 1'b1;
				conv_tag_out   <= aas_tag(next_idx);
				cur_r          <= next_idx;
				last_r         <= next_idx;
			end
		end
	end

	// a tick during a conversion is kept, not dropped
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_r <= 1'b0;
		end else if (!active || !go_r || manual) begin
			pend_r <= 1'b0;
		end else if (tick) begin
			pend_r <= 1'b1;
		end else if (state_r == ST_IDLE && trigger) begin
			pend_r <= 1'b0;
		end
	end

	// core codes pass through untouched: mV and temp scales are its own
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			data_r <= 12'h000;
			tag_r  <= 4'h0;
		end else if (finish) begin
			data_r <= data_s2_r;
			tag_r  <= aas_tag(cur_r);
		end
	end

	// read mux and bus answer
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_out  <= 32'h00000000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= access && !pready_out;
			pslverr_out <= access && !pready_out && !aas_mapped(paddr_in);
			prdata_out  <= 32'h00000000;
			if (access && !pready_out && !pwrite_in) begin
				case (paddr_in)
					A_RESULT:  prdata_out <= {16'h0000, tag_r, data_r};
					A_CONTROL: prdata_out <= {16'h0000, on_r, go_r, 1'b0,
						slp_r, 6'h00, rate_r};
					A_SOURCE:  prdata_out <= {25'h0000000, pick_r[4], 1'b0,
						pick_r[3], 1'b0, pick_r[2:0]};
					default:   prdata_out <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // aas_sequencer

// ### verif/aas_sequencer_properties.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
module aas_seq_chk (
	input wire        clk_in,
	input wire        rst_b_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire [17:0] paddr_in,
	input wire [31:0] prdata_out,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        off_state_in,
	input wire        conv_power_out,
	input wire        conv_start_out,
	input wire [3:0]  conv_tag_out,
	input wire        conv_done_in
);
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	wire mapped = paddr_in == 18'h100B4 || paddr_in == 18'h100B8 ||
		paddr_in == 18'h100BC;
	a_ready_wait: assert property (psel_in && penable_in && !pready_out
		|=> pready_out) else $error("pready late");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held");
	a_err_map: assert property (pready_out |-> pslverr_out == !mapped)
		else $error("pslverr wrong");
	a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("prdata not idle");
	a_start_gap: assert property (
		conv_start_out |=> !conv_start_out [*4])
		else $error("start too soon");
	a_start_pwr: assert property (
		conv_start_out |-> conv_power_out)
		else $error("start unpowered");
	a_tag_code: assert property (
		conv_start_out |-> conv_tag_out inside
		{4'h1, 4'h2, 4'h3, 4'h5, 4'h7}) else $error("bad tag");
	a_tag_hold: assert property (
		$changed(conv_tag_out) |-> conv_start_out)
		else $error("tag moved");
	a_off_power: assert property (
		off_state_in |-> ##[1:2] !conv_power_out)
		else $error("power kept in off");
	cover property (conv_start_out);
	cover property (pready_out && pslverr_out);
	cover property (off_state_in && conv_power_out);
endmodule // aas_seq_chk
bind aas_sequencer aas_seq_chk u_chk (.clk_in, .rst_b_in, .psel_in,
	.penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
	.off_state_in, .conv_power_out, .conv_start_out, .conv_tag_out,
	.conv_done_in);

// ### verif/aas_conv_model.sv
// behavioural converter core answering start pulses
`timescale 1ns/1ps
module aas_conv_model (
	input  wire        clk_in,
	input  wire        start_in,
	input  wire [3:0]  tag_in,
	input  wire [4:0]  lat_in,
	output reg         done_out,
	output reg  [11:0] data_out
);
	reg [5:0] cnt_r = 6'h00;
	initial done_out = 1'b0;
	initial data_out = 12'hFFF;
	// data scrambles while not valid so stale codes never match
	always @(posedge clk_in) begin
		if (start_in) begin
			done_out <= 1'b0;
			cnt_r <= {1'b0, lat_in} + 6'h03;
		end else if (cnt_r == 6'h01) begin
			done_out <= 1'b1;
			data_out <= {tag_in, 8'h5A};
		end
		if (!start_in && cnt_r != 6'h00)
			cnt_r <= cnt_r - 6'h01;
		if (!done_out && cnt_r != 6'h01)
			data_out <= ~data_out;
	end
endmodule // aas_conv_model

// ### verif/aas_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "aas_defines.vh"
module aas_sequencer_tb;
	localparam [17:0] RES = {`AAS_IDX_RESULT, 2'b00};
	localparam [17:0] CTL = {`AAS_IDX_CONTROL, 2'b00};
	localparam [17:0] SRC = {`AAS_IDX_SOURCE, 2'b00};
	localparam [19:0] TAGV = 20'h75321;
	reg         clk_in = 0, rst_b_in = 0, sel = 0, en = 0, wr = 0;
	reg         off = 0, slp = 0, e;
	reg  [17:0] pa = 0;
	reg  [31:0] wd = 0, rd;
	reg  [4:0]  lat = 1;
	wire [31:0] prd;
	wire        rdy, err, pwon, st, dn;
	wire [3:0]  tg;
	wire [11:0] dat;
	integer     err_count = 0, tests_run = 0, n = 0, i, j, k;
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (st) n <= n + 1;
	aas_sequencer #(.CLK_HZ(4000)) dut (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .psel_in(sel), .penable_in(en),
		.pwrite_in(wr), .paddr_in(pa), .pwdata_in(wd), .prdata_out(prd),
		.pready_out(rdy), .pslverr_out(err), .off_state_in(off),
		.sleep_state_in(slp), .conv_power_out(pwon), .conv_start_out(st),
		.conv_tag_out(tg), .conv_done_in(dn), .conv_data_in(dat));
	aas_conv_model cm (.clk_in(clk_in), .start_in(st), .tag_in(tg),
		.lat_in(lat), .done_out(dn), .data_out(dat));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("FAIL %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task xfer(input w, input [17:0] a, input [31:0] d);
		begin
			sel <= 1;
			wr <= w;
			pa <= a;
			wd <= d;
			@(posedge clk_in);
			en <= 1;
			i = 0;
			do begin
				@(posedge clk_in);
				i = i + 1;
			end while (rdy !== 1'b1 && i < 20);
			if (rdy !== 1'b1) begin
				chk(0, 1);
				give_verdict;
			end
			rd = prd;
			e = err;
			sel <= 0;
			en <= 0;
			// one idle edge so the next call never re-drives sel at once
			@(posedge clk_in);
		end
	endtask
	task rdc(input [17:0] a, input [31:0] x);
		begin
			xfer(0, a, 0);
			chk(rd, x);
		end
	endtask
	// window counts allow one tick of phase slack
	task rate(input [5:0] c, input integer w, input integer lo, hi);
		begin
			xfer(1, CTL, {18'h3, 8'h0, c});
			k = n;
			repeat (w) @(posedge clk_in);
			chk(n - k >= lo && n - k <= hi, 1);
			xfer(1, CTL, 32'h8000);
			repeat (40) @(posedge clk_in);
		end
	endtask
	initial begin
		#1000000;
		chk(0, 1);
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1;
		rdc(RES, 0);
		rdc(CTL, 0);
		rdc(SRC, 0);
		xfer(0, 18'h100C0, 0);
		chk(e, 1);
		xfer(1, RES, 32'hFFFF);
		rdc(RES, 0);
		xfer(1, SRC, 32'h57);
		rdc(SRC, 32'h57);
		$display("registers test done");
		for (k = 0; k < 5; k = k + 1) begin
			lat <= k[0] ? 5'd20 : 5'd1;
			xfer(1, CTL, 32'hC000);
			j = 0;
			do begin
				xfer(0, CTL, 0);
				j = j + 1;
			end while (rd[14] && j < 40);
			rdc(CTL, 32'h8000);
			rdc(RES, {TAGV[4*k +: 4], TAGV[4*k +: 4], 8'h5A});
		end
		$display("manual test done");
		rate(6'd1, 4100, 2, 3);
		rate(6'd31, 1000, 14, 16);
		rate(6'd33, 1000, 3, 5);
		rate(6'd32, 1000, 0, 0);
		xfer(1, CTL, 32'h801F);
		k = n;
		repeat (500) @(posedge clk_in);
		chk(n - k, 0);
		$display("rate test done");
		xfer(1, CTL, 32'hC020);
		off <= 1;
		@(posedge clk_in);
		off <= 0;
		rdc(CTL, 32'h4020);
		chk(pwon, 0);
		slp <= 1;
		xfer(1, CTL, 32'h8000);
		repeat (3) @(posedge clk_in);
		chk(pwon, 0);
		xfer(1, CTL, 32'h9000);
		repeat (3) @(posedge clk_in);
		chk(pwon, 1);
		$display("power test done");
		give_verdict;
	end
endmodule // aas_sequencer_tb
